// ### cau_pkg.sv
// cau_pkg: shared opcodes, sizes, flag layout and reset values for the cpu arithmetic unit.
// assumes the instruction decoder encodes requests with these codes.
// ====================================================================
// package
package cau_pkg;
   // operand size codes
   localparam logic [1:0] SZ_B   = 2'h0;
   localparam logic [1:0] SZ_W   = 2'h1;
   localparam logic [1:0] SZ_L   = 2'h2;
   // operation codes
   localparam logic [4:0] OP_SUM      = 5'h00;
   localparam logic [4:0] OP_DIFF     = 5'h01;
   localparam logic [4:0] OP_COMPARE  = 5'h02;
   localparam logic [4:0] OP_CADD     = 5'h03;
   localparam logic [4:0] OP_BSUB     = 5'h04;
   localparam logic [4:0] OP_UP       = 5'h05;
   localparam logic [4:0] OP_DOWN     = 5'h06;
   localparam logic [4:0] OP_APLUS    = 5'h07;
   localparam logic [4:0] OP_AMINUS   = 5'h08;
   localparam logic [4:0] OP_DADJ_ADD = 5'h09;
   localparam logic [4:0] OP_DADJ_SUB = 5'h0A;
   localparam logic [4:0] OP_UMUL     = 5'h0B;
   localparam logic [4:0] OP_SMUL     = 5'h0C;
   localparam logic [4:0] OP_UDIV     = 5'h0D;
   localparam logic [4:0] OP_SDIV     = 5'h0E;
   localparam logic [4:0] OP_NEG      = 5'h0F;
   localparam logic [4:0] OP_ZW       = 5'h10;
   localparam logic [4:0] OP_SW       = 5'h11;
   localparam logic [4:0] OP_TSET     = 5'h12;
   localparam logic [4:0] OP_MULACC   = 5'h13;
   localparam logic [4:0] OP_ACC_CLR  = 5'h14;
   localparam logic [4:0] OP_ACC_LD   = 5'h15;
   localparam logic [4:0] OP_ACC_ST   = 5'h16;
   localparam logic [4:0] OP_AND      = 5'h17;
   localparam logic [4:0] OP_OR       = 5'h18;
   localparam logic [4:0] OP_XOR      = 5'h19;
   localparam logic [4:0] OP_NOT      = 5'h1A;
   // flag bit positions and reset value
   localparam int unsigned FL_C = 0;
   localparam int unsigned FL_V = 1;
   localparam int unsigned FL_Z = 2;
   localparam int unsigned FL_N = 3;
   localparam int unsigned FL_H = 4;
   localparam logic [4:0]  FLAGS_RST = 5'h00;
   localparam logic [31:0] RES_RST   = 32'h0000_0000;
   // accumulator widths and step values
   localparam int unsigned ACC_WIDE = 42;
   localparam logic [2:0]  STEP_ONE  = 3'h1;
   localparam logic [2:0]  STEP_TWO  = 3'h2;
   localparam logic [2:0]  STEP_FOUR = 3'h4;
   localparam logic [41:0] ACC_RST   = 42'h000_0000_0000;
   localparam logic [31:0] SAT_POS   = 32'h7FFF_FFFF;
   localparam logic [31:0] SAT_NEG   = 32'h8000_0000;
endpackage

// ### cau_unit_if.sv
// cau_unit_if: links the core datapath to its multiply/divide and accumulator units.
// assumes all three sit in one clock domain.
// ====================================================================
// interface
interface cau_unit_if;
   logic [15:0] md_a;
   logic [15:0] md_b;
   logic [31:0] md_n;
   logic        md_word;
   logic        md_signed;
   logic [31:0] md_prod;
   logic [15:0] md_quot;
   logic [15:0] md_rem;
   logic        md_zero;
   logic        acc_clr;
   logic        acc_ld;
   logic        acc_mul;
   logic        acc_sat;
   logic [31:0] acc_din;
   logic [15:0] acc_x;
   logic [15:0] acc_y;
   logic [41:0] acc_q;
   modport core (output md_a, md_b, md_n, md_word, md_signed, acc_clr, acc_ld, acc_mul,
                 acc_sat, acc_din, acc_x, acc_y,
                 input md_prod, md_quot, md_rem, md_zero, acc_q);
   modport muldiv (input md_a, md_b, md_n, md_word, md_signed,
                   output md_prod, md_quot, md_rem, md_zero);
   modport acc (input acc_clr, acc_ld, acc_mul, acc_sat, acc_din, acc_x, acc_y,
                output acc_q);
endinterface

// ### cau_muldiv.sv
// cau_muldiv: combinational multiply and divide for byte and word operands.
// assumes the core registers the results; divide by zero yields zero quotient.
// ====================================================================
// multiply / divide
module cau_muldiv import cau_pkg::*; (
   cau_unit_if.muldiv u
);
   logic signed [16:0] ma, mb;
   logic signed [33:0] prod;
   logic        [31:0] n, d, un, ud, uq, ur, q, r;
   logic               nn, dn;
   // operands widened with or without sign, then one 17x17 signed product
   always_comb begin
      ma   = u.md_word ? {u.md_signed & u.md_a[15], u.md_a}
                       : {{9{u.md_signed & u.md_a[7]}}, u.md_a[7:0]};
      mb   = u.md_word ? {u.md_signed & u.md_b[15], u.md_b}
                       : {{9{u.md_signed & u.md_b[7]}}, u.md_b[7:0]};
      prod = ma * mb;
      u.md_prod = prod[31:0];
   end
   // divide on magnitudes, then restore signs: quotient truncates toward zero
   always_comb begin
      n  = u.md_word ? u.md_n : {{16{u.md_signed & u.md_n[15]}}, u.md_n[15:0]};
      d  = u.md_word ? {{16{u.md_signed & u.md_b[15]}}, u.md_b}
                     : {{24{u.md_signed & u.md_b[7]}}, u.md_b[7:0]};
      nn = u.md_signed & n[31];
      dn = u.md_signed & d[31];
      un = nn ? 32'(-n) : n;
      ud = dn ? 32'(-d) : d;
      u.md_zero = (ud == 32'h0000_0000);
      uq = u.md_zero ? 32'h0000_0000 : un / ud;
      ur = u.md_zero ? 32'h0000_0000 : un % ud;
      q  = (nn ^ dn) ? 32'(-uq) : uq;
      r  = nn ? 32'(-ur) : ur;
      u.md_quot = q[15:0];
      u.md_rem  = r[15:0];
   end
endmodule // cau_muldiv

// ### cau_acc.sv
// cau_acc: 42-bit multiply-accumulate register with saturating and wrapping modes.
// assumes one request strobe at most per enabled cycle.
// ====================================================================
// accumulator
module cau_acc import cau_pkg::*; (
   input wire logic clk,
   input wire logic nrst,
   input wire logic ce,
   cau_unit_if.acc  u
);
   logic signed [31:0] prod;
   logic        [41:0] wide;
   logic        [32:0] sum33;
   logic        [31:0] sat;
   logic        [41:0] next_acc;
   logic        [41:0] acc;
   // signed 16x16 product, then a wrapping and a clamping sum
   always_comb begin
      prod  = $signed(u.acc_x) * $signed(u.acc_y);
      wide  = acc + {{10{prod[31]}}, prod};
      sum33 = {acc[31], acc[31:0]} + {prod[31], prod};
      // clamp when the 33-bit sum leaves the 32-bit range
      if (sum33[32] != sum33[31]) begin
         sat = sum33[32] ? SAT_NEG : SAT_POS;
      end else begin
         sat = sum33[31:0];
      end
      next_acc = u.acc_sat ? {{10{sat[31]}}, sat} : wide;
   end
   // accumulator register
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         acc <= ACC_RST;
      end else if (ce) begin
         if (u.acc_clr) begin
            acc <= ACC_RST;
         end else if (u.acc_ld) begin
            acc <= {{10{u.acc_din[31]}}, u.acc_din};
         end else if (u.acc_mul) begin
            acc <= next_acc;
         end
      end
   end
   assign u.acc_q = acc;
endmodule // cau_acc

// ### cau_alu.sv
// cau_alu: integer arithmetic and logic datapath of a 16-bit cpu core.
// assumes the decoder presents operands and takes one result per enabled cycle.
// Contract
// - add and subtract byte, word, longword
// - carry add and borrow subtract, byte only
// - step by one or two, byte one
// - address adjust by 1, 2, 4
// - decimal adjust byte using flags
// - unsigned multiply 8x8 or 16x16
// - signed multiply 8x8 or 16x16
// - unsigned divide, quotient and remainder
// - signed divide, same widths
// - compare sets flags, keeps destination
// - negate is zero minus value
// - zero widen low half
// - sign widen low half
// - test byte, set bit seven
// - multiply accumulate, saturating or wrapping
// - accumulator clear to zero
// - accumulator load and store, longword
// - and, or, xor with register/immediate
// - ones complement of register
// - keep n, z, v, c flags
// ====================================================================
// top
module cau_alu import cau_pkg::*; (
   input  wire logic        REF_CLK,
   input  wire logic        NRST,
   input  wire logic        CE,
   input  wire logic        REQ_VALID,
   input  wire logic [4:0]  REQ_OP,
   input  wire logic [1:0]  REQ_SIZE,
   input  wire logic        REQ_IMM,
   input  wire logic [31:0] IMM_DATA,
   input  wire logic [2:0]  REQ_STEP,
   input  wire logic [31:0] DST_DATA,
   input  wire logic [31:0] SRC_DATA,
   input  wire logic        ACC_SAT_MODE,
   input  wire logic        FLAG_LOAD,
   input  wire logic [4:0]  FLAG_DATA,
   output logic      [31:0] RES_DATA,
   output logic             RES_WRITE,
   output logic             DONE,
   output logic             REQ_ERROR,
   output logic      [4:0]  FLAGS
);
   cau_unit_if u ();
   cau_muldiv u_md (.u(u));
   cau_acc u_acc (.clk(REF_CLK), .nrst(NRST), .ce(CE), .u(u));

   logic        taken, bad, wr, nz;
   logic [31:0] src, mask, ad_a, ad_b, res, next_res;
   logic [32:0] ad_s;
   logic        ad_sub, ad_cin, ad_c, ad_v, ad_h;
   logic [7:0]  dv, daa_res, das_res;
   logic        da_hi, da_lo;
   logic [1:0]  wsz;
   logic [4:0]  next_flags;

   function automatic logic [31:0] size_mask(input logic [1:0] sz);
      case (sz)
         SZ_B:    return 32'h0000_00FF;
         SZ_W:    return 32'h0000_FFFF;
         default: return 32'hFFFF_FFFF;
      endcase
   endfunction
   function automatic logic top_bit(input logic [31:0] x, input logic [1:0] sz);
      case (sz)
         SZ_B:    return x[7];
         SZ_W:    return x[15];
         default: return x[31];
      endcase
   endfunction
   function automatic logic carry_at(input logic [32:0] s, input logic [1:0] sz);
      case (sz)
         SZ_B:    return s[8];
         SZ_W:    return s[16];
         default: return s[32];
      endcase
   endfunction
   function automatic logic half_at(input logic [31:0] x, input logic [1:0] sz);
      case (sz)
         SZ_B:    return x[4];
         SZ_W:    return x[12];
         default: return x[28];
      endcase
   endfunction
   // ====================================================================
   // request decode and legality
   assign taken = CE & REQ_VALID;
   assign src   = REQ_IMM ? IMM_DATA : SRC_DATA;
   // illegal size/step combinations are refused rather than guessed
   always_comb begin
      case (REQ_OP)
         OP_SUM, OP_DIFF, OP_COMPARE, OP_NEG,
         OP_AND, OP_OR, OP_XOR, OP_NOT:   bad = (REQ_SIZE == 2'h3);
         OP_CADD, OP_BSUB, OP_DADJ_ADD,
         OP_DADJ_SUB, OP_TSET:            bad = (REQ_SIZE != SZ_B);
         OP_UP, OP_DOWN:                  bad = (REQ_SIZE == 2'h3) || !((REQ_STEP == STEP_ONE)
                                             || (REQ_STEP == STEP_TWO && REQ_SIZE != SZ_B));
         OP_APLUS, OP_AMINUS:             bad = (REQ_SIZE != SZ_L) || !(REQ_STEP == STEP_ONE
                                             || REQ_STEP == STEP_TWO || REQ_STEP == STEP_FOUR);
         OP_UMUL, OP_SMUL, OP_UDIV,
         OP_SDIV:                         bad = (REQ_SIZE != SZ_B) && (REQ_SIZE != SZ_W);
         OP_ZW, OP_SW:                    bad = (REQ_SIZE != SZ_W) && (REQ_SIZE != SZ_L);
         OP_MULACC, OP_ACC_CLR, OP_ACC_LD,
         OP_ACC_ST:                       bad = 1'b0;
         default:                         bad = 1'b1;
      endcase
   end
   // ====================================================================
   // shared adder: every add, subtract, step, compare and negate uses it
   always_comb begin
      mask   = size_mask(REQ_SIZE);
      ad_a   = DST_DATA & mask;
      ad_b   = src;
      ad_sub = 1'b0;
      ad_cin = 1'b0;
      case (REQ_OP)
         OP_DIFF, OP_COMPARE: begin
            ad_sub = 1'b1;
            ad_cin = 1'b1;
         end
         OP_CADD:  ad_cin = FLAGS[FL_C];
         OP_BSUB: begin
            ad_sub = 1'b1;
            ad_cin = ~FLAGS[FL_C];
         end
         OP_UP, OP_APLUS:  ad_b = {29'h0000_0000, REQ_STEP};
         OP_DOWN, OP_AMINUS: begin
            ad_b   = {29'h0000_0000, REQ_STEP};
            ad_sub = 1'b1;
            ad_cin = 1'b1;
         end
         OP_NEG: begin
            ad_a   = 32'h0000_0000;
            ad_b   = DST_DATA;
            ad_sub = 1'b1;
            ad_cin = 1'b1;
         end
         default: ;
      endcase
      // subtract as a plus inverted b plus one; carry out inverts to borrow
      ad_b = (ad_sub ? ~ad_b : ad_b) & mask;
      ad_s = {1'b0, ad_a} + {1'b0, ad_b} + {32'h0000_0000, ad_cin};
      ad_c = carry_at(ad_s, REQ_SIZE) ^ ad_sub;
      ad_v = (top_bit(ad_a, REQ_SIZE) == top_bit(ad_b, REQ_SIZE))
             && (top_bit(ad_s[31:0], REQ_SIZE) != top_bit(ad_a, REQ_SIZE));
      ad_h = half_at(ad_a ^ ad_b ^ ad_s[31:0], REQ_SIZE) ^ ad_sub;
   end
   // ====================================================================
   // decimal adjust: half carry and carry pick the nibble corrections
   always_comb begin
      dv      = DST_DATA[7:0];
      da_hi   = FLAGS[FL_C] || (dv > 8'h99);
      da_lo   = FLAGS[FL_H] || (dv[3:0] > 4'h9);
      daa_res = dv + {(da_hi ? 4'h6 : 4'h0), (da_lo ? 4'h6 : 4'h0)};
      das_res = dv - {(FLAGS[FL_C] ? 4'h6 : 4'h0), (FLAGS[FL_H] ? 4'h6 : 4'h0)};
   end
   // ====================================================================
   // unit operands
   assign u.md_a      = DST_DATA[15:0];
   assign u.md_b      = SRC_DATA[15:0];
   assign u.md_n      = DST_DATA;
   assign u.md_word   = (REQ_SIZE == SZ_W);
   assign u.md_signed = (REQ_OP == OP_SMUL) || (REQ_OP == OP_SDIV);
   assign u.acc_clr   = taken && (REQ_OP == OP_ACC_CLR);
   assign u.acc_ld    = taken && (REQ_OP == OP_ACC_LD);
   assign u.acc_mul   = taken && (REQ_OP == OP_MULACC);
   assign u.acc_sat   = ACC_SAT_MODE;
   assign u.acc_din   = SRC_DATA;
   assign u.acc_x     = DST_DATA[15:0];
   assign u.acc_y     = SRC_DATA[15:0];
   // ====================================================================
   // result select and flag update
   always_comb begin
      res        = ad_s[31:0];
      wsz        = REQ_SIZE;
      wr         = 1'b1;
      nz         = 1'b0;
      next_flags = FLAGS;
      case (REQ_OP)
         OP_SUM, OP_DIFF, OP_CADD, OP_BSUB, OP_NEG, OP_COMPARE: begin
            nz              = 1'b1;
            next_flags[FL_C] = ad_c;
            next_flags[FL_V] = ad_v;
            next_flags[FL_H] = ad_h;
            wr              = (REQ_OP != OP_COMPARE);
         end
         OP_UP, OP_DOWN: begin
            nz              = 1'b1;
            next_flags[FL_V] = ad_v; // carry is kept by steps
         end
         OP_APLUS, OP_AMINUS: ; // address adjust leaves flags alone
         OP_DADJ_ADD: begin
            res             = {24'h00_0000, daa_res};
            nz              = 1'b1;
            next_flags[FL_C] = da_hi;
         end
         OP_DADJ_SUB: begin
            res = {24'h00_0000, das_res};
            nz  = 1'b1;
         end
         OP_UMUL, OP_SMUL: begin
            res = u.md_prod;
            wsz = (REQ_SIZE == SZ_B) ? SZ_W : SZ_L;
            nz  = (REQ_OP == OP_SMUL);
         end
         OP_UDIV, OP_SDIV: begin
            // remainder in the upper half, quotient in the lower half
            res = (REQ_SIZE == SZ_B) ? {16'h0000, u.md_rem[7:0], u.md_quot[7:0]}
                                     : {u.md_rem, u.md_quot};
            wsz = (REQ_SIZE == SZ_B) ? SZ_W : SZ_L;
            wr  = ~u.md_zero; // zero divisor leaves destination intact
            next_flags[FL_N] = top_bit(SRC_DATA, REQ_SIZE);
            next_flags[FL_Z] = u.md_zero;
         end
         OP_ZW: begin
            res = (REQ_SIZE == SZ_W) ? {24'h00_0000, DST_DATA[7:0]}
                                     : {16'h0000, DST_DATA[15:0]};
            nz  = 1'b1;
            next_flags[FL_V] = 1'b0;
         end
         OP_SW: begin
            res = (REQ_SIZE == SZ_W) ? {{24{DST_DATA[7]}}, DST_DATA[7:0]}
                                     : {{16{DST_DATA[15]}}, DST_DATA[15:0]};
            nz  = 1'b1;
            next_flags[FL_V] = 1'b0;
         end
         OP_TSET: begin
            res = {24'h00_0000, DST_DATA[7:0] | 8'h80};
            wsz = SZ_B;
            next_flags[FL_N] = DST_DATA[7]; // flags compare the byte read, not written
            next_flags[FL_Z] = (DST_DATA[7:0] == 8'h00);
            next_flags[FL_V] = 1'b0;
         end
         OP_MULACC, OP_ACC_CLR, OP_ACC_LD: wr = 1'b0;
         OP_ACC_ST: begin
            res = u.acc_q[31:0];
            wsz = SZ_L;
         end
         OP_AND, OP_OR, OP_XOR, OP_NOT: begin
            case (REQ_OP)
               OP_AND:  res = DST_DATA & src;
               OP_OR:   res = DST_DATA | src;
               OP_XOR:  res = DST_DATA ^ src;
               default: res = ~DST_DATA;
            endcase
            nz = 1'b1;
            next_flags[FL_V] = 1'b0;
         end
         default: wr = 1'b0;
      endcase
      if (nz) begin
         next_flags[FL_N] = top_bit(res, wsz);
         next_flags[FL_Z] = ((res & size_mask(wsz)) == 32'h0000_0000);
      end
      // upper bits of the destination outside the write width survive
      next_res = (DST_DATA & ~size_mask(wsz)) | (res & size_mask(wsz));
   end
   // ====================================================================
   // flag register: an accepted operation wins over an external load
   always_ff @(posedge REF_CLK or negedge NRST) begin
      if (!NRST) begin
         FLAGS <= FLAGS_RST;
      end else if (CE) begin
         if (taken && !bad) begin
            FLAGS <= next_flags;
         end else if (FLAG_LOAD) begin
            FLAGS <= FLAG_DATA;
         end
      end
   end
   // result register holds until the next written result
   always_ff @(posedge REF_CLK or negedge NRST) begin
      if (!NRST) begin
         RES_DATA <= RES_RST;
      end else if (CE && taken && !bad && wr) begin
         RES_DATA <= next_res;
      end
   end
   // handshake pulses, one enabled cycle each
   always_ff @(posedge REF_CLK or negedge NRST) begin
      if (!NRST) begin
         RES_WRITE <= 1'b0;
         DONE      <= 1'b0;
         REQ_ERROR <= 1'b0;
      end else if (CE) begin
         RES_WRITE <= taken && !bad && wr;
         DONE      <= taken;
         REQ_ERROR <= taken && bad;
      end
   end
   // ====================================================================
   // assertions
   property p_sum;
      @(posedge REF_CLK) disable iff (!NRST)
      taken && REQ_OP == OP_SUM && REQ_SIZE == SZ_W && !REQ_IMM
      |=> RES_DATA[15:0] == 16'($past(DST_DATA[15:0]) + $past(SRC_DATA[15:0]));
   endproperty
   a_sum: assert property (p_sum) else $error("word sum wrong");
   property p_cadd;
      @(posedge REF_CLK) disable iff (!NRST)
      taken && REQ_OP == OP_CADD && REQ_SIZE == SZ_B
      |=> RES_DATA[7:0] == 8'($past(DST_DATA[7:0]) + $past(src[7:0])
                              + {7'h00, $past(FLAGS[FL_C])});
   endproperty
   a_cadd: assert property (p_cadd) else $error("carry add wrong");
   property p_step;
      @(posedge REF_CLK) disable iff (!NRST)
      taken && (REQ_OP == OP_UP || REQ_OP == OP_DOWN) && REQ_SIZE == SZ_B && REQ_STEP == STEP_TWO
      |=> REQ_ERROR && !RES_WRITE;
   endproperty
   a_step: assert property (p_step) else $error("byte step of two accepted");
   property p_compare;
      @(posedge REF_CLK) disable iff (!NRST)
      taken && REQ_OP == OP_COMPARE |=> !RES_WRITE && DONE;
   endproperty
   a_compare: assert property (p_compare) else $error("compare wrote result");
   property p_neg;
      @(posedge REF_CLK) disable iff (!NRST)
      taken && REQ_OP == OP_NEG && REQ_SIZE == SZ_B
      |=> RES_DATA[7:0] == 8'(8'h00 - $past(DST_DATA[7:0]));
   endproperty
   a_neg: assert property (p_neg) else $error("negate wrong");
   property p_tset;
      @(posedge REF_CLK) disable iff (!NRST)
      taken && REQ_OP == OP_TSET && REQ_SIZE == SZ_B
      |=> RES_DATA[7] && RES_DATA[6:0] == $past(DST_DATA[6:0])
          && FLAGS[FL_Z] == ($past(DST_DATA[7:0]) == 8'h00);
   endproperty
   a_tset: assert property (p_tset) else $error("test and set wrong");
   property p_clr;
      @(posedge REF_CLK) disable iff (!NRST)
      taken && REQ_OP == OP_ACC_CLR ##1 !taken ##1 taken && REQ_OP == OP_ACC_ST
      |=> RES_DATA == 32'h0000_0000 && RES_WRITE;
   endproperty
   a_clr: assert property (p_clr) else $error("accumulator not cleared");
   property p_zw;
      @(posedge REF_CLK) disable iff (!NRST)
      taken && REQ_OP == OP_ZW && REQ_SIZE == SZ_W
      |=> RES_DATA[15:8] == 8'h00 && RES_DATA[7:0] == $past(DST_DATA[7:0]);
   endproperty
   a_zw: assert property (p_zw) else $error("zero widen wrong");
   property p_umul;
      @(posedge REF_CLK) disable iff (!NRST)
      taken && REQ_OP == OP_UMUL && REQ_SIZE == SZ_B
      |=> RES_DATA[15:0] == {8'h00, $past(DST_DATA[7:0])} * {8'h00, $past(SRC_DATA[7:0])};
   endproperty
   a_umul: assert property (p_umul) else $error("unsigned product wrong");
   property p_zflag;
      @(posedge REF_CLK) disable iff (!NRST)
      taken && REQ_OP == OP_OR && REQ_SIZE == SZ_L && !REQ_IMM
      |=> FLAGS[FL_Z] == (($past(DST_DATA) | $past(SRC_DATA)) == 32'h0000_0000);
   endproperty
   a_zflag: assert property (p_zflag) else $error("zero flag wrong");
   c_chain: cover property (@(posedge REF_CLK) disable iff (!NRST)
      taken && REQ_OP == OP_CADD ##1 taken && REQ_OP == OP_CADD);
   c_div0: cover property (@(posedge REF_CLK) disable iff (!NRST)
      taken && REQ_OP == OP_UDIV && u.md_zero);
   c_sat: cover property (@(posedge REF_CLK) disable iff (!NRST)
      taken && REQ_OP == OP_MULACC && ACC_SAT_MODE);
   c_err: cover property (@(posedge REF_CLK) disable iff (!NRST) REQ_ERROR);
endmodule // cau_alu

// ### cau_rf_model.sv
// cau_rf_model: destination register as the decoder side sees it.
// assumes write-back lands on the enabled edge that sees the write pulse.
// ====================================================================
// destination register
module cau_rf_model (
   input  wire logic        clk,
   input  wire logic        nrst,
   input  wire logic        ce,
   input  wire logic        wr,
   input  wire logic [31:0] wdata,
   output logic      [31:0] dst
);
   // a frozen core must not write, so ce gates the capture
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) dst <= 32'h0000_0000;
      else if (ce && wr) dst <= wdata;
   end
endmodule // cau_rf_model

// ### testbench.sv
// testbench: directed checks of the arithmetic unit, one task per scenario.
// assumes one-cycle answer after the taking edge.
// ====================================================================
// bench
module testbench import cau_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk = 0, nrst = 0, ce = 1, vld = 0, imm = 0, sat = 0, fld = 0;
   logic [4:0]  op = 0, fdat = 0;
   logic [1:0]  sz = 0;
   logic [2:0]  st = 0;
   logic [31:0] idat = 0, d = 0, s = 0;
   wire  logic [31:0] res, rf;
   wire  logic        wr, done, err;
   wire  logic [4:0]  fl;
   int          fail_count = 0, compares = 0;
   // 125 mhz core clock
   always #4 clk = ~clk;
   cau_alu dut (.REF_CLK(clk), .NRST(nrst), .CE(ce), .REQ_VALID(vld), .REQ_OP(op),
      .REQ_SIZE(sz), .REQ_IMM(imm), .IMM_DATA(idat), .REQ_STEP(st), .DST_DATA(d),
      .SRC_DATA(s), .ACC_SAT_MODE(sat), .FLAG_LOAD(fld), .FLAG_DATA(fdat), .RES_DATA(res),
      .RES_WRITE(wr), .DONE(done), .REQ_ERROR(err), .FLAGS(fl));
   cau_rf_model rfm (.clk(clk), .nrst(nrst), .ce(ce), .wr(wr), .wdata(res), .dst(rf));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         fail_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // one request held over one taking edge, then settled outputs
   task automatic go(input logic [4:0] o, input logic [1:0] z, input logic [2:0] t,
                     input logic i, input logic [31:0] a, input logic [31:0] b);
      @(posedge clk);
      op <= o;
      sz <= z;
      st <= t;
      imm <= i;
      idat <= b;
      s <= b;
      d <= a;
      vld <= 1'b1;
      @(posedge clk);
      vld <= 1'b0;
      #1;
   endtask
   task automatic ex(input logic [4:0] o, input logic [1:0] z, input logic [2:0] t,
                     input logic i, input logic [31:0] a, b, e);
      go(o, z, t, i, a, b);
      chk(res, e);
   endtask
   task automatic er(input logic [4:0] o, input logic [1:0] z, input logic [2:0] t);
      go(o, z, t, 1'b0, 32'h0, 32'h0);
      chk({30'h0, done, err}, 32'h3);
   endtask
   task automatic t_arith;
      ex(OP_SUM, SZ_W, 0, 0, 32'h1234_FFFF, 32'h1, 32'h1234_0000);
      chk({27'h0, fl}, 32'h15);
      ex(OP_DIFF, SZ_B, 0, 0, 32'hAB00_0005, 32'h7, 32'hAB00_00FE);
      chk({31'h0, fl[FL_N]}, 32'h1);
      go(OP_COMPARE, SZ_L, 0, 0, 32'h5, 32'h5);
      chk({30'h0, wr, fl[FL_Z]}, 32'h1);
      @(posedge clk);
      #1;
      chk(rf, 32'hAB00_00FE);
      er(OP_SUM, 2'h3, 0);
   endtask
   task automatic t_carry;
      @(posedge clk);
      fld <= 1'b1;
      fdat <= 5'h01;
      @(posedge clk);
      fld <= 1'b0;
      ex(OP_CADD, SZ_B, 0, 1, 32'h10, 32'h20, 32'h31);
      ex(OP_BSUB, SZ_B, 0, 0, 32'h10, 32'h1, 32'h0F);
      er(OP_CADD, SZ_W, 0);
      ex(OP_DADJ_ADD, SZ_B, 0, 0, 32'h0F, 32'h0, 32'h15);
   endtask
   task automatic t_step;
      ex(OP_UP, SZ_W, STEP_TWO, 0, 32'h00FF, 32'h0, 32'h0101);
      ex(OP_DOWN, SZ_B, STEP_ONE, 0, 32'h0, 32'h0, 32'hFF);
      er(OP_DOWN, SZ_B, STEP_TWO);
      ex(OP_AMINUS, SZ_L, STEP_FOUR, 0, 32'h2, 32'h0, 32'hFFFF_FFFE);
      er(OP_APLUS, SZ_W, STEP_ONE);
   endtask
   task automatic t_muldiv;
      ex(OP_UMUL, SZ_B, 0, 0, 32'hFF, 32'hFF, 32'hFE01);
      ex(OP_SMUL, SZ_W, 0, 0, 32'hFFFF, 32'h2, 32'hFFFF_FFFE);
      ex(OP_UDIV, SZ_B, 0, 0, 32'h0107, 32'h10, 32'h0710);
      ex(OP_SDIV, SZ_W, 0, 0, 32'hFFFF_FFF9, 32'h2, 32'hFFFF_FFFD);
      go(OP_UDIV, SZ_B, 0, 0, 32'h0107, 32'h0);
      chk({29'h0, wr, done, fl[FL_Z]}, 32'h3);
   endtask
   task automatic t_logic;
      ex(OP_NEG, SZ_B, 0, 0, 32'h1, 32'h0, 32'hFF);
      ex(OP_ZW, SZ_W, 0, 0, 32'h1280, 32'h0, 32'h0080);
      ex(OP_SW, SZ_L, 0, 0, 32'h8001, 32'h0, 32'hFFFF_8001);
      ex(OP_TSET, SZ_B, 0, 0, 32'h0, 32'h0, 32'h80);
      chk({31'h0, fl[FL_Z]}, 32'h1);
      ex(OP_AND, SZ_L, 0, 1, 32'hF0F0, 32'h0FF0, 32'h00F0);
      ex(OP_OR, SZ_L, 0, 0, 32'hF0F0, 32'h0FF0, 32'hFFF0);
      ex(OP_XOR, SZ_L, 0, 1, 32'hF0F0, 32'h0FF0, 32'hFF00);
      ex(OP_NOT, SZ_B, 0, 0, 32'h5A, 32'h0, 32'hA5);
   endtask
   task automatic t_acc;
      go(OP_ACC_LD, SZ_L, 0, 0, 32'h0, 32'h1234_5678);
      go(OP_ACC_CLR, SZ_L, 0, 0, 32'h0, 32'h0);
      ex(OP_ACC_ST, SZ_L, 0, 0, 32'h0, 32'h0, 32'h0);
      go(OP_MULACC, SZ_L, 0, 0, 32'h3, 32'hFFFE);
      ex(OP_ACC_ST, SZ_L, 0, 0, 32'h0, 32'h0, 32'hFFFF_FFFA);
      @(posedge clk);
      sat <= 1'b1;
      go(OP_ACC_LD, SZ_L, 0, 0, 32'h0, 32'h7FFF_FFFF);
      go(OP_MULACC, SZ_L, 0, 0, 32'h2, 32'h3);
      ex(OP_ACC_ST, SZ_L, 0, 0, 32'h0, 32'h0, 32'h7FFF_FFFF);
   endtask
   // a frozen core must ignore a held request and keep its result
   task automatic t_freeze;
      @(posedge clk);
      ce <= 1'b0;
      go(OP_SUM, SZ_L, 0, 0, 32'h1, 32'h1);
      chk({31'h0, done}, 32'h0);
      chk(res, 32'h7FFF_FFFF);
      @(posedge clk);
      ce <= 1'b1;
   endtask
   task automatic report_and_stop;
      $display("compares %0d fail_count %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // main sequence after a 16-cycle reset
   initial begin
      repeat (16) @(posedge clk);
      nrst <= 1'b1;
      t_arith();
      t_carry();
      t_step();
      t_muldiv();
      t_logic();
      t_acc();
      t_freeze();
      report_and_stop();
   end
   // watchdog, far beyond the hundred or so cycles the run needs
   initial begin
      #200_000;
      fail_count++;
      report_and_stop();
   end
endmodule // testbench
